//--- asl_map.vh
/*
 * Constants of the audio-synchronised LED control block: slave address,
 * control byte layout, reset values and timing counts.
 * Assumes a 10 MHz system clock; included by bare name.
 */
`ifndef ASL_MAP_VH
`define ASL_MAP_VH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define ASL_CLK_HZ 10000000
`define ASL_PWM_STEPS 256
`define ASL_PWM_HZ_FAST 15000
`define ASL_PWM_HZ_MID 60
`define ASL_PWM_HZ_SLOW 7
`define ASL_PWM_HZ_SLOWEST 4
`define ASL_DIV_FAST (`ASL_CLK_HZ / (`ASL_PWM_HZ_FAST * `ASL_PWM_STEPS))
`define ASL_DIV_MID (`ASL_CLK_HZ / (`ASL_PWM_HZ_MID * `ASL_PWM_STEPS))
`define ASL_DIV_SLOW (`ASL_CLK_HZ / (`ASL_PWM_HZ_SLOW * `ASL_PWM_STEPS))
`define ASL_DIV_SLOWEST (`ASL_CLK_HZ / (`ASL_PWM_HZ_SLOWEST * `ASL_PWM_STEPS))
`define ASL_SHUFFLE_MS 3200
`define ASL_SHUFFLE_CYCLES (`ASL_SHUFFLE_MS * (`ASL_CLK_HZ / 1000))

// ----------------------------------------------------------------------
// Serial slave address: fixed upper six bits, low bit from the strap
// ----------------------------------------------------------------------
`define ASL_ADDR_HI 6'h3D

// ----------------------------------------------------------------------
// Control byte: [7:5] register select, [4:0] payload
// ----------------------------------------------------------------------
`define ASL_SEL_MSB 7
`define ASL_SEL_LSB 5
`define ASL_REG_PATTERN 3'h0
`define ASL_REG_MODE 3'h1
`define ASL_REG_FREQ 3'h2
`define ASL_PAT_SEL_BIT 3
`define ASL_PAT_THIRD_COLOR_OUTPUT_BIT 2
`define ASL_PAT_SECOND_COLOR_OUTPUT_BIT 1
`define ASL_PAT_FIRST_COLOR_OUTPUT_BIT 0
`define ASL_MODE_SHUFFLE_BIT 0
`define ASL_FREQ_MSB 1
`define ASL_FREQ_LSB 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ASL_RST_PATTERN 4'h0
`define ASL_RST_SHUFFLE 1'h0
`define ASL_RST_FREQ 2'h1

`endif

//--- asl_pwm_chan.v
/*
 * One PWM output channel: a duty comparator on a free-running step count.
 * Assumes the step counter comes from the parent on the same clock.
 */
`timescale 1ns/1ps

module asl_pwm_chan #(
    parameter WIDTH = 8
) (
    clk,
    rst,
    stepCount,
    duty,
    forceOn,
    pwmOut
);
    input wire clk;
    input wire rst;
    input wire [WIDTH-1:0] stepCount;
    input wire [WIDTH-1:0] duty;
    input wire forceOn;
    output reg pwmOut;

    // ------------------------------------------------------------------
    // Comparator
    // ------------------------------------------------------------------
    // A count of N steps cannot show N of N high, so full duty is forced.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pwmOut <= 1'b0;
        end else begin
            pwmOut <= forceOn | (stepCount < duty);
        end
    end
endmodule

//--- asl_twi_slave.v
/*
 * Write-only two-wire serial slave. Takes synchronised clock and data
 * levels, recognises start and stop, matches the address and emits one
 * strobe per received data byte. Assumes inputs already on clk.
 */
`timescale 1ns/1ps
`include "asl_map.vh"

module asl_twi_slave (
    clk,
    rst,
    sclLevel,
    sdaLevel,
    addrBit,
    sdaOe,
    byteValid,
    byteData
);
    input wire clk;
    input wire rst;
    input wire sclLevel;
    input wire sdaLevel;
    input wire addrBit;
    output reg sdaOe;
    output reg byteValid;
    output reg [7:0] byteData;

    localparam ST_IDLE = 2'h0;
    localparam ST_RX = 2'h1;
    localparam ST_ACK = 2'h2;

    reg [1:0] state_q;
    reg [3:0] bitCnt_q;
    reg [7:0] shift_q;
    reg isAddr_q;
    reg sclPrev_q;
    reg sdaPrev_q;
    wire sclRise = sclLevel & ~sclPrev_q;
    wire sclFall = ~sclLevel & sclPrev_q;
    wire startSeen = sclLevel & sclPrev_q & sdaPrev_q & ~sdaLevel;
    wire stopSeen = sclLevel & sclPrev_q & ~sdaPrev_q & sdaLevel;
    wire addrMatch = (shift_q[7:1] == {`ASL_ADDR_HI, addrBit}) & ~shift_q[0];

    // ------------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            isAddr_q <= 1'b0;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
            sdaOe <= 1'b0;
            byteValid <= 1'b0;
            byteData <= 8'h00;
        end else begin
            sclPrev_q <= sclLevel;
            sdaPrev_q <= sdaLevel;
            byteValid <= 1'b0;
            if (stopSeen) begin
                state_q <= ST_IDLE;
                sdaOe <= 1'b0;
            end else if (startSeen) begin
                state_q <= ST_RX;
                bitCnt_q <= 4'h0;
                isAddr_q <= 1'b1;
                sdaOe <= 1'b0;
            end else begin
                case (state_q)
                    ST_RX: begin
                        if (sclRise && bitCnt_q != 4'h8) begin
                            shift_q <= {shift_q[6:0], sdaLevel};
                            bitCnt_q <= bitCnt_q + 4'h1;
                        end else if (sclFall && bitCnt_q == 4'h8) begin
                            if (isAddr_q) begin
                                if (addrMatch) begin
                                    state_q <= ST_ACK;
                                    sdaOe <= 1'b1;
                                end else begin
                                    state_q <= ST_IDLE;
                                end
                            end else begin
                                state_q <= ST_ACK;
                                sdaOe <= 1'b1;
                                byteValid <= 1'b1;
                                byteData <= shift_q;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (sclFall) begin
                            sdaOe <= 1'b0;
                            state_q <= ST_RX;
                            bitCnt_q <= 4'h0;
                            isAddr_q <= 1'b0;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

//--- asl_led_ctrl.v
/*
 * Control logic of a three-channel audio-synchronised LED PWM driver.
 * Holds the serial pin synchronisers, the control registers written over
 * the serial slave, the band shuffler and the PWM time base.
 * Assumes band amplitude levels arrive on clk from the analog front end,
 * and that the open-drain data wire is resolved outside from sdaOe.
 */

`timescale 1ns/1ps
`include "asl_map.vh"

module asl_led_ctrl #(
    parameter DIV_FAST = `ASL_DIV_FAST,
    parameter DIV_MID = `ASL_DIV_MID,
    parameter DIV_SLOW = `ASL_DIV_SLOW,
    parameter DIV_SLOWEST = `ASL_DIV_SLOWEST,
    parameter SHUFFLE_CYCLES = `ASL_SHUFFLE_CYCLES,
    parameter LEVEL_W = 8
) (
    clk,
    rst,
    sclPin,
    sdaIn,
    sdaOut,
    sdaOe,
    adrPin,
    lowBandLevel,
    midBandLevel,
    highBandLevel,
    firstColorOutput,
    secondColorOutput,
    thirdColorOutput,
    patternMode,
    firstOutputDirectOn,
    secondOutputDirectOn,
    thirdOutputDirectOn,
    bandShuffleEnable,
    shuffleActive,
    pwmFreqSel,
    bandOrder
);
    input wire clk;
    input wire rst;
    input wire sclPin;
    input wire sdaIn;
    output wire sdaOut;
    output wire sdaOe;
    input wire adrPin;
    input wire [LEVEL_W-1:0] lowBandLevel;
    input wire [LEVEL_W-1:0] midBandLevel;
    input wire [LEVEL_W-1:0] highBandLevel;
    output wire firstColorOutput;
    output wire secondColorOutput;
    output wire thirdColorOutput;
    output reg patternMode;
    output reg firstOutputDirectOn;
    output reg secondOutputDirectOn;
    output reg thirdOutputDirectOn;
    output reg bandShuffleEnable;
    output reg shuffleActive;
    output reg [1:0] pwmFreqSel;
    output reg [2:0] bandOrder;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Band index (0 low, 1 mid, 2 high) feeding output outIdx under
    // permutation perm; the six codes cover every ordering of three.
    function [1:0] bandFor;
        input [2:0] perm;
        input [1:0] outIdx;
        reg [5:0] map;
        begin
            map = 6'h24;
            case (perm)
                3'h0: map = 6'h24;
                3'h1: map = 6'h18;
                3'h2: map = 6'h21;
                3'h3: map = 6'h09;
                3'h4: map = 6'h12;
                3'h5: map = 6'h06;
                default: map = 6'h24;
            endcase
            case (outIdx)
                2'h0: bandFor = map[1:0];
                2'h1: bandFor = map[3:2];
                default: bandFor = map[5:4];
            endcase
        end
    endfunction

    function [LEVEL_W-1:0] pickLevel;
        input [1:0] band;
        input [LEVEL_W-1:0] lowL;
        input [LEVEL_W-1:0] midL;
        input [LEVEL_W-1:0] highL;
        begin
            case (band)
                2'h0: pickLevel = lowL;
                2'h1: pickLevel = midL;
                default: pickLevel = highL;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    reg sclMeta_q;
    reg sclSync_q;
    reg sdaMeta_q;
    reg sdaSync_q;
    reg adrMeta_q;
    reg adrSync_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sclMeta_q <= 1'b1;
            sclSync_q <= 1'b1;
            sdaMeta_q <= 1'b1;
            sdaSync_q <= 1'b1;
            adrMeta_q <= 1'b0;
            adrSync_q <= 1'b0;
        end else begin
            sclMeta_q <= sclPin;
            sclSync_q <= sclMeta_q;
            sdaMeta_q <= sdaIn;
            sdaSync_q <= sdaMeta_q;
            adrMeta_q <= adrPin;
            adrSync_q <= adrMeta_q;
        end
    end

    // ------------------------------------------------------------------
    // Serial slave
    // ------------------------------------------------------------------
    // A 400 kHz bus gives 25 system clocks per serial period, ample for
    // the two synchroniser stages and the edge detector.
    wire byteValid;
    wire [7:0] byteData;

    // The line is only ever pulled low; the pull-up makes the high level.
    assign sdaOut = 1'b0;

    asl_twi_slave uSlave (
        .clk(clk),
        .rst(rst),
        .sclLevel(sclSync_q),
        .sdaLevel(sdaSync_q),
        .addrBit(adrSync_q),
        .sdaOe(sdaOe),
        .byteValid(byteValid),
        .byteData(byteData)
    );

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // Bytes for unlisted selects belong to the analog settings and are
    // dropped here; the master still sees them acknowledged.
    wire [2:0] regSel = byteData[`ASL_SEL_MSB:`ASL_SEL_LSB];
    localparam [3:0] PAT_RST = `ASL_RST_PATTERN;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            patternMode <= PAT_RST[`ASL_PAT_SEL_BIT];
            firstOutputDirectOn <= PAT_RST[`ASL_PAT_FIRST_COLOR_OUTPUT_BIT];
            secondOutputDirectOn <= PAT_RST[`ASL_PAT_SECOND_COLOR_OUTPUT_BIT];
            thirdOutputDirectOn <= PAT_RST[`ASL_PAT_THIRD_COLOR_OUTPUT_BIT];
            bandShuffleEnable <= `ASL_RST_SHUFFLE;
            pwmFreqSel <= `ASL_RST_FREQ;
        end else if (byteValid) begin
            case (regSel)
                `ASL_REG_PATTERN: begin
                    patternMode <= byteData[`ASL_PAT_SEL_BIT];
                    firstOutputDirectOn <= byteData[`ASL_PAT_FIRST_COLOR_OUTPUT_BIT];
                    secondOutputDirectOn <= byteData[`ASL_PAT_SECOND_COLOR_OUTPUT_BIT];
                    thirdOutputDirectOn <= byteData[`ASL_PAT_THIRD_COLOR_OUTPUT_BIT];
                end
                `ASL_REG_MODE: begin
                    bandShuffleEnable <= byteData[`ASL_MODE_SHUFFLE_BIT];
                end
                `ASL_REG_FREQ: begin
                    pwmFreqSel <= byteData[`ASL_FREQ_MSB:`ASL_FREQ_LSB];
                end
                default: begin
                    pwmFreqSel <= pwmFreqSel;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // PWM time base
    // ------------------------------------------------------------------
    // No rate is an exact divisor of the clock; the fast rate lands well
    // above the nominal rate, the slow rates a little above.
    reg [15:0] divCnt_q;
    reg [LEVEL_W-1:0] stepCnt_q;
    reg [15:0] divLimit;

    always @* begin
        case (pwmFreqSel)
            2'h0: divLimit = DIV_FAST[15:0];
            2'h1: divLimit = DIV_MID[15:0];
            2'h2: divLimit = DIV_SLOW[15:0];
            default: divLimit = DIV_SLOWEST[15:0];
        endcase
    end

    wire stepTick = (divCnt_q >= divLimit - 16'h1);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            divCnt_q <= 16'h0000;
            stepCnt_q <= {LEVEL_W{1'b0}};
        end else if (stepTick) begin
            divCnt_q <= 16'h0000;
            stepCnt_q <= stepCnt_q + {{(LEVEL_W-1){1'b0}}, 1'b1};
        end else begin
            divCnt_q <= divCnt_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Band shuffler
    // ------------------------------------------------------------------
    // The step is drawn from a small LFSR and never zero, so every
    // interval really changes the assignment.
    reg [25:0] shufCnt_q;
    reg [4:0] lfsr_q;
    wire shufOn = bandShuffleEnable & ~patternMode;
    wire shufWrap = (shufCnt_q == SHUFFLE_CYCLES[25:0] - 26'h1);
    wire [2:0] shufStep = (lfsr_q[2:0] % 3'h5) + 3'h1;
    wire [3:0] nextSum = {1'b0, bandOrder} + {1'b0, shufStep};

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            shufCnt_q <= 26'h0000000;
            lfsr_q <= 5'h01;
            bandOrder <= 3'h0;
            shuffleActive <= 1'b0;
        end else begin
            shuffleActive <= shufOn;
            lfsr_q <= {lfsr_q[3:0], lfsr_q[4] ^ lfsr_q[2]};
            if (!shufOn) begin
                shufCnt_q <= 26'h0000000;
                bandOrder <= 3'h0;
            end else if (shufWrap) begin
                shufCnt_q <= 26'h0000000;
                if (nextSum >= 4'h6) begin
                    bandOrder <= nextSum[2:0] - 3'h6;
                end else begin
                    bandOrder <= nextSum[2:0];
                end
            end else begin
                shufCnt_q <= shufCnt_q + 26'h0000001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Duty selection
    // ------------------------------------------------------------------
    // In pattern mode the duty is zero and the direct bit forces full on.
    reg [LEVEL_W-1:0] duty1;
    reg [LEVEL_W-1:0] duty2;
    reg [LEVEL_W-1:0] duty3;
    wire force1 = patternMode & firstOutputDirectOn;
    wire force2 = patternMode & secondOutputDirectOn;
    wire force3 = patternMode & thirdOutputDirectOn;

    always @* begin
        if (patternMode) begin
            duty1 = {LEVEL_W{1'b0}};
            duty2 = {LEVEL_W{1'b0}};
            duty3 = {LEVEL_W{1'b0}};
        end else begin
            duty1 = pickLevel(bandFor(bandOrder, 2'h0), lowBandLevel, midBandLevel,
                highBandLevel);
            duty2 = pickLevel(bandFor(bandOrder, 2'h1), lowBandLevel, midBandLevel,
                highBandLevel);
            duty3 = pickLevel(bandFor(bandOrder, 2'h2), lowBandLevel, midBandLevel,
                highBandLevel);
        end
    end

    // ------------------------------------------------------------------
    // Output channels
    // ------------------------------------------------------------------
    asl_pwm_chan #(.WIDTH(LEVEL_W)) uChan1 (
        .clk(clk),
        .rst(rst),
        .stepCount(stepCnt_q),
        .duty(duty1),
        .forceOn(force1),
        .pwmOut(firstColorOutput)
    );

    asl_pwm_chan #(.WIDTH(LEVEL_W)) uChan2 (
        .clk(clk),
        .rst(rst),
        .stepCount(stepCnt_q),
        .duty(duty2),
        .forceOn(force2),
        .pwmOut(secondColorOutput)
    );

    asl_pwm_chan #(.WIDTH(LEVEL_W)) uChan3 (
        .clk(clk),
        .rst(rst),
        .stepCount(stepCnt_q),
        .duty(duty3),
        .forceOn(force3),
        .pwmOut(thirdColorOutput)
    );
endmodule

//--- asl_twi_master.sv
/* Bus master model for the two-wire serial slave: drives clock and data.
   Assumes the bench resolves the data wire with a pull-up. */
`timescale 1ns/1ps
module asl_twi_master (
    input wire logic clk,
    input wire logic sdaWire,
    output logic sclPin,
    output logic sdaLow
);
    // Quarter bit in clocks: 40 clocks a bit keeps the bus at 250 kHz.
    localparam int Q = 10;
    initial begin
        sclPin = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic wq();
        repeat (Q) @(negedge clk);
    endtask
    task automatic start();
        sdaLow = 1'b1;
        wq();
        sclPin = 1'b0;
        wq();
    endtask
    // Data moves only while the clock is low, so no bit reads as start or stop.
    task automatic bitOut(input logic b, output logic s);
        sdaLow = ~b;
        wq();
        sclPin = 1'b1;
        wq();
        s = sdaWire;
        wq();
        sclPin = 1'b0;
        wq();
    endtask
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitOut(b[i], s);
        end
        bitOut(1'b1, s);
        ack = ~s;
    endtask
    task automatic stop();
        sdaLow = 1'b1;
        wq();
        sclPin = 1'b1;
        wq();
        sdaLow = 1'b0;
        wq();
    endtask
endmodule

//--- asl_led_props.sv
/* Concurrent checks on the LED control block's ports.
   Assumes one clock and an active-high asynchronous reset. */
`timescale 1ns/1ps
module asl_led_props #(
    parameter int SHUFFLE_CYCLES = 32000000,
    parameter int LEVEL_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclPin,
    input wire logic sdaOe,
    input wire logic [LEVEL_W-1:0] lowBandLevel,
    input wire logic firstColorOutput,
    input wire logic secondColorOutput,
    input wire logic thirdColorOutput,
    input wire logic patternMode,
    input wire logic firstOutputDirectOn,
    input wire logic secondOutputDirectOn,
    input wire logic thirdOutputDirectOn,
    input wire logic bandShuffleEnable,
    input wire logic shuffleActive,
    input wire logic [2:0] bandOrder
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic [31:0] gapCount_q;
    logic [2:0] prevOrder_q;
    // Cycles since the order last moved; a slack of a few cycles covers sync lag.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gapCount_q <= '0;
            prevOrder_q <= 3'h0;
        end else begin
            prevOrder_q <= bandOrder;
            if (!shuffleActive || bandOrder != prevOrder_q) begin
                gapCount_q <= '0;
            end else begin
                gapCount_q <= gapCount_q + 32'h1;
            end
        end
    end
    chk_ack_edge: assert property ($changed(sdaOe) |-> !sclPin)
        else $error("acknowledge moved while clock high");
    chk_order_range: assert property (bandOrder <= 3'h5)
        else $error("band order out of range");
    chk_order_home: assert property ((!bandShuffleEnable || patternMode) [*3]
        |-> bandOrder == 3'h0)
        else $error("band order not identity while idle");
    chk_shuffle_gate: assert property (patternMode [*2] |-> !shuffleActive)
        else $error("shuffle active in pattern mode");
    chk_shuffle_early: assert property (shuffleActive && bandShuffleEnable
        && !patternMode && bandOrder != prevOrder_q |-> gapCount_q >= SHUFFLE_CYCLES - 3)
        else $error("band order moved too early");
    chk_shuffle_late: assert property (gapCount_q <= SHUFFLE_CYCLES + 2)
        else $error("band order did not move in time");
    chk_first_on: assert property ((patternMode && firstOutputDirectOn) [*3]
        |-> firstColorOutput)
        else $error("first output not fully on");
    chk_second_off: assert property ((patternMode && !secondOutputDirectOn) [*3]
        |-> !secondColorOutput)
        else $error("second output not fully off");
    chk_third_direct: assert property ((patternMode
        && $stable(thirdOutputDirectOn)) [*3] |-> thirdColorOutput == thirdOutputDirectOn)
        else $error("third output does not follow its bit");
    chk_low_dark: assert property ((!patternMode && !shuffleActive
        && bandOrder == 3'h0 && lowBandLevel == '0) [*3] |-> !firstColorOutput)
        else $error("first output lit with silent low band");
    cover property ($rose(sdaOe));
    cover property ($rose(patternMode));
    cover property ($rose(shuffleActive));
    cover property (shuffleActive && $changed(bandOrder));
endmodule
bind asl_led_ctrl asl_led_props #(
    .SHUFFLE_CYCLES(SHUFFLE_CYCLES),
    .LEVEL_W(LEVEL_W)
) chkU (
    .clk(clk),
    .rst(rst),
    .sclPin(sclPin),
    .sdaOe(sdaOe),
    .lowBandLevel(lowBandLevel),
    .firstColorOutput(firstColorOutput),
    .secondColorOutput(secondColorOutput),
    .thirdColorOutput(thirdColorOutput),
    .patternMode(patternMode),
    .firstOutputDirectOn(firstOutputDirectOn),
    .secondOutputDirectOn(secondOutputDirectOn),
    .thirdOutputDirectOn(thirdOutputDirectOn),
    .bandShuffleEnable(bandShuffleEnable),
    .shuffleActive(shuffleActive),
    .bandOrder(bandOrder)
);

//--- asl_tb.sv
/* Self-checking bench for the LED control block with a bus master model.
   Assumes short dividers and a short shuffle interval set below. */
`timescale 1ns/1ps
module tb;
    localparam int SH = 300;
    logic clk, rst, adrPin;
    logic [7:0] lowL, midL, highL;
    wire sclPin, sdaLow, sdaOe, sdaOut, out1, out2, out3, pm, d1, d2, d3, se, sa;
    wire [1:0] fs;
    wire [2:0] bo;
    wire sdaWire = ~(sdaLow | (sdaOe & ~sdaOut));
    wire [6:0] st = {pm, d3, d2, d1, se, fs};
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    asl_led_ctrl #(.DIV_FAST(2), .DIV_MID(4), .DIV_SLOW(6), .DIV_SLOWEST(8),
        .SHUFFLE_CYCLES(SH), .LEVEL_W(8)) dut_u (.clk(clk), .rst(rst),
        .sclPin(sclPin), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .adrPin(adrPin), .lowBandLevel(lowL), .midBandLevel(midL),
        .highBandLevel(highL), .firstColorOutput(out1), .secondColorOutput(out2),
        .thirdColorOutput(out3), .patternMode(pm), .firstOutputDirectOn(d1),
        .secondOutputDirectOn(d2), .thirdOutputDirectOn(d3),
        .bandShuffleEnable(se), .shuffleActive(sa), .pwmFreqSel(fs), .bandOrder(bo));
    asl_twi_master m_u (.clk(clk), .sdaWire(sdaWire), .sclPin(sclPin), .sdaLow(sdaLow));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic summarize();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // A hung handshake must still reach the verdict.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic xfer(input logic [7:0] ab, input logic [7:0] db[$], output logic [3:0] ak);
        logic a;
        ak = '0;
        m_u.start();
        m_u.sendByte(ab, a);
        ak[0] = a;
        if (a) begin
            foreach (db[i]) begin
                m_u.sendByte(db[i], a);
                ak[i+1] = a;
            end
        end
        m_u.stop();
    endtask
    logic [14:0] rows [11] = '{{8'h0F, 7'h79}, {8'h0A, 7'h51}, {8'h05, 7'h29},
        {8'h21, 7'h2D}, {8'h40, 7'h2C}, {8'h43, 7'h2F}, {8'h42, 7'h2E},
        {8'h41, 7'h2D}, {8'h20, 7'h29}, {8'hE7, 7'h29}, {8'h00, 7'h01}};
    int divs [4] = '{2, 4, 6, 8};
    initial begin
        logic [3:0] ak;
        logic seen;
        int c1, c2, c3;
        rst = 1'b1;
        adrPin = 1'b0;
        lowL = 8'h00;
        midL = 8'h00;
        highL = 8'h00;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        foreach (rows[i]) begin
            xfer(8'hF4, '{rows[i][14:7]}, ak);
            chk("ack", 16'(ak), 16'h3);
            chk("regs", 16'(st), 16'(rows[i][6:0]));
        end
        $display("Test table done");
        adrPin = 1'b1;
        xfer(8'hF4, '{8'h0F}, ak);
        chk("wrong addr", 16'(ak), 16'h0);
        xfer(8'hF7, '{}, ak);
        chk("read addr", 16'(ak), 16'h0);
        xfer(8'hF6, '{8'h0D}, ak);
        chk("strap addr", 16'(ak), 16'h3);
        chk("strap regs", 16'(st), 16'h69);
        $display("Test address done");
        xfer(8'hF6, '{8'h21}, ak);
        repeat (SH + 20) begin
            @(negedge clk);
            chk("pattern", 16'({out3, out2, out1, sa, bo}), 16'h50);
        end
        // Leaving pattern mode with the stored enable must start shuffling.
        xfer(8'hF6, '{8'h05}, ak);
        seen = 1'b0;
        repeat (SH + 20) begin
            @(negedge clk);
            if (bo !== 3'h0) begin
                seen = 1'b1;
            end
        end
        chk("shuffled", 16'(seen), 16'h1);
        $display("Test shuffle done");
        xfer(8'hF6, '{8'h20, 8'h40, 8'h00}, ak);
        chk("multi ack", 16'(ak), 16'hF);
        chk("multi regs", 16'(st), 16'h00);
        lowL = 8'h40;
        midL = 8'h80;
        highL = 8'hC0;
        for (int f = 0; f < 4; f++) begin
            xfer(8'hF6, '{8'h40 | 8'(f)}, ak);
            c1 = 0;
            c2 = 0;
            c3 = 0;
            repeat (256 * divs[f]) begin
                @(negedge clk);
                c1 += int'(out1);
                c2 += int'(out2);
                c3 += int'(out3);
            end
            chk("duty low", 16'(c1), 16'(divs[f] * 64));
            chk("duty mid", 16'(c2), 16'(divs[f] * 128));
            chk("duty high", 16'(c3), 16'(divs[f] * 192));
        end
        $display("Test duty done");
        rst = 1'b1;
        repeat (8) @(negedge clk);
        chk("reset", 16'({st, bo, sdaOe, out1, out2, out3}), 16'h0080);
        rst = 1'b0;
        $display("Test reset done");
        summarize();
    end
endmodule
